// >>> rtl/pio_pkg.sv
package pio_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int PORT_WIDTH = 16;
    localparam int NOTIFY_COUNT = 24;
    localparam int NOTIFY_REG1_WIDTH = 16;
    localparam int NOTIFY_REG2_WIDTH = 8;
    localparam int ADC_COUNT = 2;
    localparam int AN_CHANNELS = 32;

    // ----------------------------------------------------------------
    // Reset values (per bit)
    // ----------------------------------------------------------------
    localparam logic DIR_RESET_BIT = 1'b1;
    localparam logic LATCH_RESET_BIT = 1'b0;
    localparam logic OPEN_DRAIN_RESET_BIT = 1'b0;
    localparam logic ANALOG_CFG_RESET_BIT = 1'b0;
    localparam logic NOTIFY_EN_RESET_BIT = 1'b0;
    localparam logic PULLUP_RESET_BIT = 1'b0;
    localparam logic FLAG_RESET_BIT = 1'b0;

    // ----------------------------------------------------------------
    // Variant masks
    // ----------------------------------------------------------------
    localparam logic [PORT_WIDTH-1:0] IMPL_MASK_DEFAULT = 16'hFFFF;
    localparam logic [PORT_WIDTH-1:0] ANALOG_MASK_DEFAULT = 16'h00FF;
    localparam logic [PORT_WIDTH-1:0] INPUT_ONLY_MASK_DEFAULT = 16'h0000;

    typedef enum logic {OWNER_PORT, OWNER_PERIPH} pin_owner_t;

endpackage

// >>> rtl/pin_ctrl_if.sv
`timescale 1ns/1ps
interface pin_ctrl_if #(parameter int W = 16);
    logic [W-1:0] dir;
    logic [W-1:0] latch;
    logic [W-1:0] od;
    logic [W-1:0] periph_en;
    logic [W-1:0] periph_active;
    logic [W-1:0] periph_out;
    logic [W-1:0] periph_oe;
    logic [W-1:0] owned;
    logic [W-1:0] port_drives;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;
    logic [W-1:0] periph_in;

    modport ctrl (
        output dir, latch, od, periph_en, periph_active, periph_out, periph_oe,
        input owned, port_drives, pin_out, pin_oe, periph_in
    );
    modport mux (
        input dir, latch, od, periph_en, periph_active, periph_out, periph_oe,
        output owned, port_drives, pin_out, pin_oe, periph_in
    );
endinterface

// >>> rtl/pin_mux.sv
`timescale 1ns/1ps
module pin_mux
    import pio_pkg::*;
#(
    parameter int W = PORT_WIDTH,
    parameter logic [W-1:0] IMPL_MASK = IMPL_MASK_DEFAULT,
    parameter logic [W-1:0] INPUT_ONLY_MASK = INPUT_ONLY_MASK_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] pin_in,
    pin_ctrl_if.mux pc
);
    logic [W-1:0] out_reg, out_next;
    logic [W-1:0] oe_reg, oe_next;
    logic [W-1:0] pin_in_reg, pin_in_next;

    // ----------------------------------------------------------------
    // Per-pin output ownership
    // ----------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_pin
        pin_owner_t owner;
        logic port_oe;
        always_comb begin
            // Input-only sharers never compete for the driver
            owner = (IMPL_MASK[i] && !INPUT_ONLY_MASK[i] && pc.periph_en[i]
                     && pc.periph_active[i]) ? OWNER_PERIPH : OWNER_PORT;
            // Open drain: drive low only, release for a one
            port_oe = IMPL_MASK[i] && !pc.dir[i]
                      && (!pc.od[i] || !pc.latch[i]);
            if (owner == OWNER_PERIPH) begin
                out_next[i] = pc.periph_out[i];
                oe_next[i] = pc.periph_oe[i];
            end else begin
                out_next[i] = pc.latch[i] && !pc.od[i];
                oe_next[i] = port_oe;
            end
            // Peripheral input is masked low in each cycle the port drives the pin
            pin_in_next[i] = IMPL_MASK[i] && pin_in[i]
                             && !(owner == OWNER_PORT && port_oe);
            pc.owned[i] = (owner == OWNER_PERIPH);
            pc.port_drives[i] = (owner == OWNER_PORT) && port_oe;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= '0;
            oe_reg <= '0;
            pin_in_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            pin_in_reg <= pin_in_next;
        end
    end

    assign pc.pin_out = out_reg;
    assign pc.pin_oe = oe_reg;
    assign pc.periph_in = pin_in_reg;
endmodule

// >>> rtl/change_notify.sv
`timescale 1ns/1ps
module change_notify
    import pio_pkg::*;
#(
    parameter int N = NOTIFY_COUNT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [N-1:0] notify_in,
    input wire logic [N-1:0] notify_enable,
    input wire logic flag_clr,
    output logic change_flag
);
    logic [N-1:0] prev_reg, prev_next;
    logic flag_reg, flag_next;

    // ----------------------------------------------------------------
    // Change detection
    // ----------------------------------------------------------------
    // Reference is sampled every cycle, so enabling a pin late never
    // reports a stale difference. No enable gates this logic: it keeps
    // watching as long as its clock runs, sleep included.
    always_comb begin
        prev_next = notify_in;
        // Set wins over a clear in the same cycle
        flag_next = (|((notify_in ^ prev_reg) & notify_enable))
                    || (flag_reg && !flag_clr);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg <= '0;
            flag_reg <= FLAG_RESET_BIT;
        end else begin
            prev_reg <= prev_next;
            flag_reg <= flag_next;
        end
    end

    assign change_flag = flag_reg;
endmodule

// >>> rtl/shared_parallel_io_port.sv
`timescale 1ns/1ps
module shared_parallel_io_port
    import pio_pkg::*;
#(
    parameter int W = PORT_WIDTH,
    parameter logic [W-1:0] IMPL_MASK = IMPL_MASK_DEFAULT,
    parameter logic [W-1:0] ANALOG_MASK = ANALOG_MASK_DEFAULT,
    parameter logic [W-1:0] INPUT_ONLY_MASK = INPUT_ONLY_MASK_DEFAULT,
    parameter int AN_BASE = 0,
    parameter bit DUAL_ADC = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [PORT_WIDTH-1:0] reg_wdata,
    input wire logic dir_wr,
    input wire logic latch_wr,
    input wire logic port_wr,
    input wire logic open_drain_wr,
    input wire logic [ADC_COUNT-1:0] cfg_low_wr,
    input wire logic [ADC_COUNT-1:0] cfg_high_wr,
    input wire logic notify_en_1_wr,
    input wire logic notify_en_2_wr,
    input wire logic pullup_1_wr,
    input wire logic pullup_2_wr,
    input wire logic change_irq_clr,
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] periph_en,
    input wire logic [W-1:0] periph_active,
    input wire logic [W-1:0] periph_out,
    input wire logic [W-1:0] periph_oe,
    input wire logic [NOTIFY_COUNT-1:0] change_notify_input,
    output logic [W-1:0] pin_direction,
    output logic [W-1:0] output_latch,
    output logic [W-1:0] pin_level_readback,
    output logic [W-1:0] open_drain_select,
    output logic [ADC_COUNT-1:0][15:0] analog_pin_config_low,
    output logic [ADC_COUNT-1:0][15:0] analog_pin_config_high,
    output logic [NOTIFY_REG1_WIDTH-1:0] change_irq_enable_1,
    output logic [NOTIFY_REG2_WIDTH-1:0] change_irq_enable_2,
    output logic [NOTIFY_REG1_WIDTH-1:0] pullup_enable_1,
    output logic [NOTIFY_REG2_WIDTH-1:0] pullup_enable_2,
    output logic change_irq,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] periph_in
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [W-1:0] dir_reg, dir_next;
    logic [W-1:0] latch_reg, latch_next;
    logic [W-1:0] od_reg, od_next;
    logic [W-1:0] readback_reg, readback_next;
    logic [ADC_COUNT-1:0][15:0] cfg_low_reg, cfg_low_next;
    logic [ADC_COUNT-1:0][15:0] cfg_high_reg, cfg_high_next;
    logic [NOTIFY_REG1_WIDTH-1:0] notify_en_1_reg, notify_en_1_next;
    logic [NOTIFY_REG2_WIDTH-1:0] notify_en_2_reg, notify_en_2_next;
    logic [NOTIFY_REG1_WIDTH-1:0] pu_1_reg, pu_1_next;
    logic [NOTIFY_REG2_WIDTH-1:0] pu_2_reg, pu_2_next;
    logic [ADC_COUNT-1:0][AN_CHANNELS-1:0] channel_cfg;
    logic [W-1:0] analog;

    pin_ctrl_if #(.W(W)) pc ();

    // ----------------------------------------------------------------
    // Analog selection
    // ----------------------------------------------------------------
    // Config bits are active low: a cleared bit in either converter wins.
    // A single-converter variant treats the second converter as digital.
    for (genvar i = 0; i < W; i++) begin : g_analog
        always_comb begin
            analog[i] = ANALOG_MASK[i] && IMPL_MASK[i]
                && (!channel_cfg[0][AN_BASE + i]
                    || (DUAL_ADC && !channel_cfg[1][AN_BASE + i]));
        end
    end

    always_comb begin
        for (int c = 0; c < ADC_COUNT; c++) begin
            channel_cfg[c] = {cfg_high_reg[c], cfg_low_reg[c]};
        end
    end

    // ----------------------------------------------------------------
    // Next-state of the software-visible registers
    // ----------------------------------------------------------------
    always_comb begin
        dir_next = dir_reg;
        latch_next = latch_reg;
        od_next = od_reg;
        cfg_low_next = cfg_low_reg;
        cfg_high_next = cfg_high_reg;
        notify_en_1_next = notify_en_1_reg;
        notify_en_2_next = notify_en_2_reg;
        pu_1_next = pu_1_reg;
        pu_2_next = pu_2_reg;
        if (dir_wr) begin
            dir_next = reg_wdata[W-1:0] & IMPL_MASK;
        end
        // A latch write beats a port write landing in the same cycle
        if (latch_wr) begin
            latch_next = reg_wdata[W-1:0] & IMPL_MASK;
        end else if (port_wr) begin
            latch_next = reg_wdata[W-1:0] & IMPL_MASK;
        end
        if (open_drain_wr) begin
            od_next = reg_wdata[W-1:0] & IMPL_MASK;
        end
        for (int c = 0; c < ADC_COUNT; c++) begin
            if (cfg_low_wr[c]) begin
                cfg_low_next[c] = reg_wdata;
            end
            if (cfg_high_wr[c]) begin
                cfg_high_next[c] = reg_wdata;
            end
        end
        if (notify_en_1_wr) begin
            notify_en_1_next = reg_wdata[NOTIFY_REG1_WIDTH-1:0];
        end
        if (notify_en_2_wr) begin
            notify_en_2_next = reg_wdata[NOTIFY_REG2_WIDTH-1:0];
        end
        if (pullup_1_wr) begin
            pu_1_next = reg_wdata[NOTIFY_REG1_WIDTH-1:0];
        end
        if (pullup_2_wr) begin
            pu_2_next = reg_wdata[NOTIFY_REG2_WIDTH-1:0];
        end
        // Analog pins read low whatever the voltage
        readback_next = pin_in & ~analog & IMPL_MASK;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_reg <= {W{DIR_RESET_BIT}} & IMPL_MASK;
            latch_reg <= {W{LATCH_RESET_BIT}};
            od_reg <= {W{OPEN_DRAIN_RESET_BIT}};
            readback_reg <= '0;
            cfg_low_reg <= {(ADC_COUNT * 16){ANALOG_CFG_RESET_BIT}};
            cfg_high_reg <= {(ADC_COUNT * 16){ANALOG_CFG_RESET_BIT}};
            notify_en_1_reg <= {NOTIFY_REG1_WIDTH{NOTIFY_EN_RESET_BIT}};
            notify_en_2_reg <= {NOTIFY_REG2_WIDTH{NOTIFY_EN_RESET_BIT}};
            pu_1_reg <= {NOTIFY_REG1_WIDTH{PULLUP_RESET_BIT}};
            pu_2_reg <= {NOTIFY_REG2_WIDTH{PULLUP_RESET_BIT}};
        end else begin
            dir_reg <= dir_next;
            latch_reg <= latch_next;
            od_reg <= od_next;
            readback_reg <= readback_next;
            cfg_low_reg <= cfg_low_next;
            cfg_high_reg <= cfg_high_next;
            notify_en_1_reg <= notify_en_1_next;
            notify_en_2_reg <= notify_en_2_next;
            pu_1_reg <= pu_1_next;
            pu_2_reg <= pu_2_next;
        end
    end

    // ----------------------------------------------------------------
    // Pin multiplexing
    // ----------------------------------------------------------------
    // Unimplemented direction bits read zero but the mux masks them, so
    // they never turn a driver on.
    assign pc.dir = dir_reg;
    assign pc.latch = latch_reg;
    assign pc.od = od_reg;
    assign pc.periph_en = periph_en;
    assign pc.periph_active = periph_active;
    assign pc.periph_out = periph_out;
    assign pc.periph_oe = periph_oe;

    pin_mux #(
        .W(W),
        .IMPL_MASK(IMPL_MASK),
        .INPUT_ONLY_MASK(INPUT_ONLY_MASK)
    ) u_pin_mux (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(pin_in),
        .pc(pc.mux)
    );

    // ----------------------------------------------------------------
    // Change notification
    // ----------------------------------------------------------------
    change_notify #(
        .N(NOTIFY_COUNT)
    ) u_change_notify (
        .clk(clk),
        .arst_n(arst_n),
        .notify_in(change_notify_input),
        .notify_enable({notify_en_2_reg, notify_en_1_reg}),
        .flag_clr(change_irq_clr),
        .change_flag(change_irq)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pin_direction = dir_reg;
    assign output_latch = latch_reg;
    assign pin_level_readback = readback_reg;
    assign open_drain_select = od_reg;
    assign analog_pin_config_low = cfg_low_reg;
    assign analog_pin_config_high = cfg_high_reg;
    assign change_irq_enable_1 = notify_en_1_reg;
    assign change_irq_enable_2 = notify_en_2_reg;
    // Pad pull-ups follow these bits directly
    assign pullup_enable_1 = pu_1_reg;
    assign pullup_enable_2 = pu_2_reg;
    assign pin_out = pc.pin_out;
    assign pin_oe = pc.pin_oe;
    assign periph_in = pc.periph_in;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_dir_write;
        @(posedge clk) disable iff (!arst_n)
        dir_wr |=> pin_direction == ($past(reg_wdata[W-1:0]) & IMPL_MASK);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not stored");

    property p_port_write;
        @(posedge clk) disable iff (!arst_n)
        (port_wr && !latch_wr) |=> output_latch == ($past(reg_wdata[W-1:0]) & IMPL_MASK);
    endproperty
    a_port_write: assert property (p_port_write)
        else $error("port write did not reach latch");

    property p_readback;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> pin_level_readback == ($past(pin_in) & ~$past(analog) & IMPL_MASK);
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback differs from sampled pins");

    property p_unimpl_zero;
        @(posedge clk) disable iff (!arst_n)
        ((pin_direction | output_latch | pin_level_readback | pin_oe | periph_in)
            & ~IMPL_MASK) == '0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit not inert");

    property p_periph_owns;
        @(posedge clk) disable iff (!arst_n)
        (pc.owned != '0) |=> ((pin_oe ^ $past(periph_oe)) & $past(pc.owned)) == '0
            && ((pin_out ^ $past(periph_out)) & $past(pc.owned)) == '0;
    endproperty
    a_periph_owns: assert property (p_periph_owns)
        else $error("active peripheral lost its pin");

    property p_no_loop;
        @(posedge clk) disable iff (!arst_n)
        (pc.port_drives != '0) |=> (periph_in & $past(pc.port_drives)) == '0;
    endproperty
    a_no_loop: assert property (p_no_loop)
        else $error("port output looped into peripheral");

    property p_open_drain;
        @(posedge clk) disable iff (!arst_n)
        (od_reg != '0) |=> (pin_oe & pin_out & $past(od_reg) & ~$past(pc.owned)) == '0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    property p_change_set;
        @(posedge clk) disable iff (!arst_n)
        (|(($past(change_notify_input) ^ change_notify_input)
            & {notify_en_2_reg, notify_en_1_reg})) ##1 1'b1 |-> change_irq;
    endproperty
    a_change_set: assert property (p_change_set)
        else $error("enabled change did not set flag");

    property p_flag_hold;
        @(posedge clk) disable iff (!arst_n)
        (change_irq && !change_irq_clr) |=> change_irq [*2] or (change_irq ##1 !change_irq);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("change flag dropped without clear");

    property p_flag_clear;
        @(posedge clk) disable iff (!arst_n)
        (change_irq_clr && ({notify_en_2_reg, notify_en_1_reg} == '0)) |=> !change_irq;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag set with no enabled input");

    c_periph_take: cover property (@(posedge clk) disable iff (!arst_n)
        pc.port_drives != '0 ##1 pc.owned != '0);
    c_change_irq: cover property (@(posedge clk) disable iff (!arst_n)
        !change_irq ##1 change_irq);
    c_analog_read: cover property (@(posedge clk) disable iff (!arst_n)
        (pin_in & analog) != '0);
    c_port_write: cover property (@(posedge clk) disable iff (!arst_n)
        port_wr ##2 pin_oe != '0);
endmodule

// >>> verif/pad_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pad and board model
// ----------------------------------------------------------------
module pad_model (
    input wire logic clk,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] ext_drive,
    input wire logic [15:0] ext_level,
    output logic [15:0] pin_in
);
    // A floating pad never holds its last value: it wanders every cycle
    logic [15:0] float_pat = 16'h5A5A;

    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // The port driver wins over the board when both drive
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_in[i] = ext_level[i];
            end else begin
                pin_in[i] = float_pat[i];
            end
        end
    end
endmodule

// >>> verif/shared_parallel_io_port_tb.sv
`timescale 1ns/1ps
module shared_parallel_io_port_tb;
    import pio_pkg::*;
    localparam int S_DIR = 0;
    localparam int S_LCH = 1;
    localparam int S_PORT = 2;
    localparam int S_ODS = 3;
    localparam int S_CL0 = 4;
    localparam int S_CL1 = 5;
    localparam int S_CH0 = 6;
    localparam int S_NE1 = 8;
    localparam int S_NE2 = 9;
    localparam int S_PU1 = 10;
    localparam int S_PU2 = 11;

    logic clk;
    logic arst_n;
    logic [15:0] reg_wdata;
    logic [11:0] stb;
    logic irq_clr;
    logic [15:0] pin_in, periph_en, periph_active, periph_out, periph_oe;
    logic [15:0] ext_drive, ext_level;
    logic [23:0] notify_in;
    logic [15:0] pin_direction, output_latch, pin_level_readback, open_drain_select;
    logic [1:0][15:0] cfg_low, cfg_high;
    logic [15:0] irq_en_1, pu_1;
    logic [7:0] irq_en_2, pu_2;
    logic change_irq;
    logic [15:0] pin_out, pin_oe, periph_in;
    int fail_count = 0;
    int checks_done = 0;

    // ----------------------------------------------------------------
    // Device and pads
    // ----------------------------------------------------------------
    // Bit 15 left unimplemented, bit 14 shared with an input-only function
    shared_parallel_io_port #(.IMPL_MASK(16'h7FFF), .INPUT_ONLY_MASK(16'h4000)) dut (
        .clk(clk), .arst_n(arst_n), .reg_wdata(reg_wdata),
        .dir_wr(stb[S_DIR]), .latch_wr(stb[S_LCH]), .port_wr(stb[S_PORT]),
        .open_drain_wr(stb[S_ODS]), .cfg_low_wr(stb[5:4]), .cfg_high_wr(stb[7:6]),
        .notify_en_1_wr(stb[S_NE1]), .notify_en_2_wr(stb[S_NE2]),
        .pullup_1_wr(stb[S_PU1]), .pullup_2_wr(stb[S_PU2]),
        .change_irq_clr(irq_clr), .pin_in(pin_in), .periph_en(periph_en),
        .periph_active(periph_active), .periph_out(periph_out), .periph_oe(periph_oe),
        .change_notify_input(notify_in), .pin_direction(pin_direction),
        .output_latch(output_latch), .pin_level_readback(pin_level_readback),
        .open_drain_select(open_drain_select), .analog_pin_config_low(cfg_low),
        .analog_pin_config_high(cfg_high), .change_irq_enable_1(irq_en_1),
        .change_irq_enable_2(irq_en_2), .pullup_enable_1(pu_1), .pullup_enable_2(pu_2),
        .change_irq(change_irq), .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in)
    );

    pad_model pads (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_drive(ext_drive), .ext_level(ext_level), .pin_in(pin_in)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Settling gap after each write also gives software its spare cycle
    task automatic wr(input int s, input logic [15:0] d);
        @(posedge clk);
        stb[s] <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        stb <= '0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic toggle_notify(input logic [23:0] m, input logic clr);
        @(posedge clk);
        notify_in <= notify_in ^ m;
        irq_clr <= clr;
        @(posedge clk);
        irq_clr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (change_irq !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        // A flag that never comes is a mismatch and ends the run
        if (change_irq !== 1'b1) begin
            fail_count++;
            summarize();
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        reg_wdata = 16'h0000;
        stb = '0;
        irq_clr = 1'b0;
        periph_en = 16'h0000;
        periph_active = 16'h0000;
        periph_out = 16'h0000;
        periph_oe = 16'h0000;
        notify_in = 24'h000000;
        ext_drive = 16'h7FFF;
        ext_level = 16'hA5A5;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(pin_direction, 16'h7FFF);
        chk(output_latch, 16'h0000);
        chk(pin_oe, 16'h0000);
        chk({cfg_low, cfg_high}, 64'h0);
        chk(pin_level_readback, 16'h2500);
        chk(change_irq, 1'b0);
        wr(S_CL0, 16'hFFFF);
        wr(S_CL1, 16'hFFFF);
        wr(S_CH0, 16'hFFFF);
        chk(pin_level_readback, 16'h25A5);
        wr(S_CL1, 16'hFFFE);
        chk(pin_level_readback, 16'h25A4);
        chk({cfg_low, cfg_high}, 64'hFFFEFFFF0000FFFF);
        wr(S_LCH, 16'hFFFF);
        chk(output_latch, 16'h7FFF);
        chk(pin_level_readback, 16'h25A4);
        // Analog-capable pins stay inputs
        wr(S_DIR, 16'h00FF);
        chk(pin_direction, 16'h00FF);
        chk(pin_oe, 16'h7F00);
        chk(pin_level_readback, 16'h7FA4);
        chk(periph_in & 16'h7F00, 16'h0000);
        wr(S_PORT, 16'h1200);
        chk(output_latch, 16'h1200);
        chk(pin_level_readback, 16'h12A4);
        wr(S_ODS, 16'h0F00);
        chk(open_drain_select, 16'h0F00);
        chk(pin_oe, 16'h7D00);
        chk(pin_out & pin_oe & 16'h0F00, 16'h0000);
        chk(pin_level_readback, 16'h10A4);
        @(posedge clk);
        periph_en <= 16'hFF00;
        periph_active <= 16'h7000;
        periph_out <= 16'h5000;
        periph_oe <= 16'h1000;
        repeat (3) @(posedge clk);
        #1;
        chk(pin_oe, 16'h5D00);
        chk(pin_out & 16'h7000, 16'h1000);
        chk(pin_level_readback, 16'h30A4);
        chk(periph_in & 16'h4D00, 16'h0000);
        wr(S_NE1, 16'h0001);
        wr(S_NE2, 16'h0010);
        chk({irq_en_2, irq_en_1}, 24'h100001);
        toggle_notify(24'h000020, 1'b0);
        chk(change_irq, 1'b0);
        toggle_notify(24'h100000, 1'b0);
        wait_irq();
        chk(change_irq, 1'b1);
        repeat (4) @(posedge clk);
        #1;
        chk(change_irq, 1'b1);
        toggle_notify(24'h000000, 1'b1);
        chk(change_irq, 1'b0);
        toggle_notify(24'h000001, 1'b1);
        chk(change_irq, 1'b1);
        // With every enable off, a change and a clear together leave it clear
        wr(S_NE1, 16'h0000);
        wr(S_NE2, 16'h0000);
        toggle_notify(24'h000001, 1'b1);
        chk(change_irq, 1'b0);
        wr(S_PU1, 16'hBEEF);
        wr(S_PU2, 16'h01C3);
        chk({pu_2, pu_1}, 24'hC3BEEF);
        // First-register pull-ups go off again while some pins are outputs; pu_2 keeps its value
        wr(S_PU1, 16'h0000);
        // Second reset in mid-run takes effect without a clock edge
        @(posedge clk);
        arst_n <= 1'b0;
        #1;
        chk(pin_direction, 16'h7FFF);
        chk(pin_oe, 16'h0000);
        chk(change_irq, 1'b0);
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        // Pin 12 stays with its active peripheral, pins 0-7 are analog again
        chk(pin_level_readback, 16'h3500);
        summarize();
    end
endmodule
